// file: src/two_wire_master_sequencer.sv
`timescale 1ns/1ps
`default_nettype none
`include "two_wire_map.svh"
// Overview of operation
// - A start request drives a Start condition on the data and clock pins.
// - The address byte with its write direction bit is sent as a byte.
// - After every sent byte the acknowledge bit is sampled and reported.
// - Command and memory address bytes follow as further sent bytes.
// - Each written byte is sent and acknowledged before the next one.
// - A restart request drives a Repeated Start without releasing the bus.
// - The address byte with its read direction bit is sent and checked.
// - A receive request clocks one byte in from the slave.
// - An acknowledge send request drives the chosen acknowledge value.
// - A stop request drives a Stop condition and releases the bus.
module two_wire_master_sequencer (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic link_clk,
    input wire logic [7:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [7:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    input wire logic data_pin_main_in,
    output logic data_pin_main_out,
    output logic data_pin_main_oe_n,
    input wire logic clock_pin_main_in,
    output logic clock_pin_main_out,
    output logic clock_pin_main_oe_n
);
    link_if lk();

    logic [15:0] bus_control;
    logic [15:0] next_ctrl;
    logic [15:0] wmask;
    logic [7:0] tx_byte;
    logic [7:0] rx_data;
    logic tx_pending, ack_status, busy;
    two_wire_pkg::op_t cur_op, next_op;
    logic want_op, launch;
    logic done_s1, done_s2, done_s3, done_pulse;
    logic aw_held, w_held, do_write;
    logic [7:0] waddr;
    logic [31:0] wdata_q;
    logic [3:0] wstrb_q;
    logic wr_ctl, wr_tx, wr_mapped;
    logic [31:0] rd_word;
    logic [1:0] rd_resp;

    // The link engine runs on the link clock and owns the pins.
    two_wire_link link_engine (
        .link_clk(link_clk),
        .aresetn(aresetn),
        .lk(lk.eng),
        .sda_in(data_pin_main_in),
        .scl_in(clock_pin_main_in),
        .sda_out(data_pin_main_out),
        .sda_oe_n(data_pin_main_oe_n),
        .scl_out(clock_pin_main_out),
        .scl_oe_n(clock_pin_main_oe_n)
    );

    // Done toggle crossing; the edge is taken between the second and third.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            done_s1 <= 1'b0;
            done_s2 <= 1'b0;
            done_s3 <= 1'b0;
        end else begin
            done_s1 <= lk.done_tgl;
            done_s2 <= done_s1;
            done_s3 <= done_s2;
        end
    end
    assign done_pulse = done_s2 ^ done_s3;

    // Write address channel; held until the matching data has arrived.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held <= 1'b0;
            awready <= 1'b1;
            waddr <= 8'h00;
        end else if (awvalid && awready) begin
            aw_held <= 1'b1;
            awready <= 1'b0;
            waddr <= awaddr;
        end else if (do_write) begin
            aw_held <= 1'b0;
            awready <= 1'b1;
        end
    end

    // Write data channel, taken independently of the address.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_held <= 1'b0;
            wready <= 1'b1;
            wdata_q <= 32'h0000_0000;
            wstrb_q <= 4'h0;
        end else if (wvalid && wready) begin
            w_held <= 1'b1;
            wready <= 1'b0;
            wdata_q <= wdata;
            wstrb_q <= wstrb;
        end else if (do_write) begin
            w_held <= 1'b0;
            wready <= 1'b1;
        end
    end

    // A write commits only once no response is still waiting.
    assign do_write = aw_held && w_held && !bvalid;
    assign wmask = {{8{wstrb_q[1]}}, {8{wstrb_q[0]}}};

    // Write decode; the status and receive words ignore writes.
    always_comb begin
        wr_ctl = 1'b0;
        wr_tx = 1'b0;
        wr_mapped = 1'b1;
        if (waddr == `OFS_BUS_CONTROL) begin
            wr_ctl = do_write;
        end else if (waddr == `OFS_TX_DATA) begin
            wr_tx = do_write && wstrb_q[0];
        end else if (waddr == `OFS_BUS_STATUS) begin
            wr_mapped = 1'b1;
        end else if (waddr == `OFS_RX_DATA) begin
            wr_mapped = 1'b1;
        end else begin
            wr_mapped = 1'b0;
        end
    end

    // Write response.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid <= 1'b0;
            bresp <= `RESP_OKAY;
        end else if (do_write) begin
            bvalid <= 1'b1;
            bresp <= wr_mapped ? `RESP_OKAY : `RESP_SLVERR;
        end else if (bready) begin
            bvalid <= 1'b0;
        end
    end

    // Read decode; reads have no side effects.
    always_comb begin
        rd_word = 32'h0000_0000;
        rd_resp = `RESP_OKAY;
        if (araddr == `OFS_BUS_CONTROL) begin
            rd_word[15:0] = bus_control;
        end else if (araddr == `OFS_BUS_STATUS) begin
            rd_word[`ST_ACK] = ack_status;
            rd_word[`ST_BUSY] = busy;
            rd_word[`ST_TX_PENDING] = tx_pending;
        end else if (araddr == `OFS_TX_DATA) begin
            rd_word[7:0] = tx_byte;
        end else if (araddr == `OFS_RX_DATA) begin
            rd_word[7:0] = rx_data;
        end else begin
            rd_resp = `RESP_SLVERR;
        end
    end

    // Read channel: one read under way, answered on the following edge.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready <= 1'b1;
            rvalid <= 1'b0;
            rdata <= 32'h0000_0000;
            rresp <= `RESP_OKAY;
        end else if (arvalid && arready) begin
            arready <= 1'b0;
            rvalid <= 1'b1;
            rdata <= rd_word;
            rresp <= rd_resp;
        end else if (rvalid && rready) begin
            arready <= 1'b1;
            rvalid <= 1'b0;
        end
    end

    // Control word: completion clears first, then a software write lands,
    // so a request written in the clearing cycle is kept.
    always_comb begin
        next_ctrl = bus_control;
        if (done_pulse) begin
            case (cur_op)
                two_wire_pkg::OP_START: begin
                    next_ctrl[`CTL_START] = 1'b0;
                    next_ctrl[`CTL_CLOCK_RELEASE] = 1'b0;
                end
                two_wire_pkg::OP_RESTART: next_ctrl[`CTL_RESTART] = 1'b0;
                two_wire_pkg::OP_STOP: next_ctrl[`CTL_STOP] = 1'b0;
                two_wire_pkg::OP_RX: next_ctrl[`CTL_RECEIVE] = 1'b0;
                two_wire_pkg::OP_ACK: next_ctrl[`CTL_ACK_SEND] = 1'b0;
                default: next_ctrl = next_ctrl;
            endcase
        end
        if (wr_ctl) begin
            next_ctrl = (next_ctrl & ~wmask) | (wdata_q[15:0] & wmask);
        end
        next_ctrl[`CTL_UNUSED] = 1'b0;
        // With the module off nothing may be requested of the bus.
        if (!next_ctrl[`CTL_MODULE_ON]) begin
            next_ctrl[4:0] = 5'h00;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bus_control <= `CTL_RESET;
        end else begin
            bus_control <= next_ctrl;
        end
    end

    // Transmit byte: a write queues one byte for the bus.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            tx_byte <= 8'h00;
            tx_pending <= 1'b0;
        end else begin
            if (done_pulse && cur_op == two_wire_pkg::OP_TX) begin
                tx_pending <= 1'b0;
            end
            if (!bus_control[`CTL_MODULE_ON]) begin
                tx_pending <= 1'b0;
            end else if (wr_tx) begin
                tx_byte <= wdata_q[7:0];
                tx_pending <= 1'b1;
            end
        end
    end

    // Pick one pending operation; a fixed order only matters if software
    // breaks the one-at-a-time habit.
    always_comb begin
        next_op = two_wire_pkg::OP_TX;
        want_op = 1'b1;
        if (bus_control[`CTL_START]) begin
            next_op = two_wire_pkg::OP_START;
        end else if (bus_control[`CTL_RESTART]) begin
            next_op = two_wire_pkg::OP_RESTART;
        end else if (bus_control[`CTL_STOP]) begin
            next_op = two_wire_pkg::OP_STOP;
        end else if (bus_control[`CTL_RECEIVE]) begin
            next_op = two_wire_pkg::OP_RX;
        end else if (bus_control[`CTL_ACK_SEND]) begin
            next_op = two_wire_pkg::OP_ACK;
        end else if (!tx_pending) begin
            want_op = 1'b0;
        end
    end
    assign launch = want_op && !busy;

    // Launch: payload is set with the toggle and stays put until done.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            busy <= 1'b0;
            cur_op <= two_wire_pkg::OP_START;
            lk.req_tgl <= 1'b0;
            lk.op <= two_wire_pkg::OP_START;
            lk.tx_byte <= 8'h00;
            lk.ack_value <= 1'b0;
        end else if (launch) begin
            busy <= 1'b1;
            cur_op <= next_op;
            lk.req_tgl <= !lk.req_tgl;
            lk.op <= next_op;
            lk.tx_byte <= tx_byte;
            lk.ack_value <= bus_control[`CTL_ACK_VALUE];
        end else if (done_pulse) begin
            busy <= 1'b0;
        end
    end

    // Results: the acknowledge of a sent byte, the byte received.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ack_status <= 1'b0;
            rx_data <= 8'h00;
        end else if (done_pulse && cur_op == two_wire_pkg::OP_TX) begin
            ack_status <= lk.cap[0];
        end else if (done_pulse && cur_op == two_wire_pkg::OP_RX) begin
            rx_data <= lk.cap[7:0];
        end
    end

    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    sequence s_launch_op(two_wire_pkg::op_t o);
        launch && next_op == o;
    endsequence
    sequence s_done_op(two_wire_pkg::op_t o);
        done_pulse && cur_op == o && !wr_ctl;
    endsequence

    chk_start_launch: assert property (s_launch_op(two_wire_pkg::OP_START)
        |=> lk.op == two_wire_pkg::OP_START && busy)
        else $error("start request did not reach the link");
    chk_tx_payload: assert property (s_launch_op(two_wire_pkg::OP_TX)
        |=> lk.tx_byte == $past(tx_byte))
        else $error("sent byte differs from queued byte");
    chk_ack_capture: assert property (done_pulse &&
        cur_op == two_wire_pkg::OP_TX |=> ack_status == $past(lk.cap[0]))
        else $error("acknowledge bit not reported");
    chk_tx_done_clear: assert property (done_pulse &&
        cur_op == two_wire_pkg::OP_TX && !wr_tx |=> !tx_pending)
        else $error("sent byte still pending");
    chk_restart_clear: assert property (s_done_op(two_wire_pkg::OP_RESTART)
        |=> !bus_control[`CTL_RESTART])
        else $error("restart request not cleared");
    chk_stop_clear: assert property (s_done_op(two_wire_pkg::OP_STOP)
        |=> !bus_control[`CTL_STOP] && !busy)
        else $error("stop request not cleared");
    chk_rx_capture: assert property (done_pulse &&
        cur_op == two_wire_pkg::OP_RX |=> rx_data == $past(lk.cap[7:0]))
        else $error("received byte not stored");
    chk_release_clear: assert property (s_done_op(two_wire_pkg::OP_START)
        |=> !bus_control[`CTL_CLOCK_RELEASE] &&
        !bus_control[`CTL_START])
        else $error("start completion left bits set");
    chk_busy_hold: assert property (launch |=> busy [*3])
        else $error("operation finished impossibly fast");
    chk_ack_value: assert property (s_launch_op(two_wire_pkg::OP_ACK)
        |=> lk.ack_value == $past(bus_control[`CTL_ACK_VALUE]))
        else $error("acknowledge value not passed on");
    chk_one_op: assert property (busy && !done_pulse |=>
        $stable(lk.req_tgl) && $stable(cur_op))
        else $error("second operation launched while busy");
endmodule
`default_nettype wire

// file: pkg/two_wire_map.svh
`ifndef TWO_WIRE_MAP_SVH
`define TWO_WIRE_MAP_SVH

// Register byte offsets on the AXI4-Lite port.
`define OFS_BUS_CONTROL 8'h00
`define OFS_BUS_STATUS 8'h04
`define OFS_TX_DATA 8'h08
`define OFS_RX_DATA 8'h0c

// Field positions in bus_control.
`define CTL_MODULE_ON 15
`define CTL_UNUSED 14
`define CTL_CLOCK_RELEASE 12
`define CTL_ACK_VALUE 5
`define CTL_ACK_SEND 4
`define CTL_RECEIVE 3
`define CTL_STOP 2
`define CTL_RESTART 1
`define CTL_START 0
`define CTL_RESET 16'h1000

// Field positions in bus_status.
`define ST_ACK 0
`define ST_BUSY 1
`define ST_TX_PENDING 2

// Bus responses.
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

// Link timing: a quarter of a 400 kHz bit on the 15 ns link clock.
`define LINK_CLK_PS 15000
`define QUARTER_NS 625
`define QUARTER_CYCLES ((`QUARTER_NS * 1000 + `LINK_CLK_PS - 1) / `LINK_CLK_PS)

`endif

// file: pkg/two_wire_pkg.sv
package two_wire_pkg;
    // Bus operations handed from the register side to the link engine.
    typedef enum logic [2:0] {OP_START, OP_RESTART, OP_STOP, OP_RX, OP_ACK,
        OP_TX} op_t;
    // Link engine states.
    typedef enum logic [1:0] {LS_IDLE, LS_COND, LS_BITS} link_state_t;
endpackage

// file: pkg/link_if.sv
`timescale 1ns/1ps
`default_nettype none
// Toggle handshake between the register side and the link engine.
interface link_if;
    logic req_tgl;
    two_wire_pkg::op_t op;
    logic [7:0] tx_byte;
    logic ack_value;
    logic done_tgl;
    logic [8:0] cap;
    modport ctl(output req_tgl, op, tx_byte, ack_value, input done_tgl, cap);
    modport eng(input req_tgl, op, tx_byte, ack_value, output done_tgl, cap);
endinterface
`default_nettype wire

// file: src/two_wire_link.sv
`timescale 1ns/1ps
`default_nettype none
`include "two_wire_map.svh"
module two_wire_link (
    input wire logic link_clk,
    input wire logic aresetn,
    link_if.eng lk,
    input wire logic sda_in,
    input wire logic scl_in,
    output logic sda_out,
    output logic sda_oe_n,
    output logic scl_out,
    output logic scl_oe_n
);
    logic [1:0] rst_sync;
    logic lrst_n;
    logic sda_s1, sda_s2, scl_s1, scl_s2;
    logic req_s1, req_s2, req_s3;
    two_wire_pkg::link_state_t state;
    two_wire_pkg::op_t op;
    logic [1:0] q;
    logic [7:0] div;
    logic [3:0] nbits;
    logic [8:0] sh;
    logic held;
    logic tick, advance, next_sda_hi, next_scl_hi;

    // The bus reset is brought into this domain before it is used.
    always_ff @(posedge link_clk) begin
        rst_sync <= {rst_sync[0], aresetn};
    end
    assign lrst_n = rst_sync[1];

    // Pins and the request toggle pass two flops before any logic.
    always_ff @(posedge link_clk) begin
        sda_s1 <= sda_in;
        sda_s2 <= sda_s1;
        scl_s1 <= scl_in;
        scl_s2 <= scl_s1;
        if (!lrst_n) begin
            req_s1 <= 1'b0;
            req_s2 <= 1'b0;
            req_s3 <= 1'b0;
        end else begin
            req_s1 <= lk.req_tgl;
            req_s2 <= req_s1;
            req_s3 <= req_s2;
        end
    end

    // A slave holding the clock low stretches the low phase of a bit.
    assign tick = (div == 8'(`QUARTER_CYCLES - 1));
    assign advance = tick && !(state == two_wire_pkg::LS_BITS &&
        q == 2'h1 && !scl_s2);

    // Quarter-bit divider, parked while idle so each step starts clean.
    always_ff @(posedge link_clk) begin
        if (!lrst_n || state == two_wire_pkg::LS_IDLE || tick) begin
            div <= 8'h00;
        end else begin
            div <= div + 8'h01;
        end
    end

    // Operation engine: one request in, one done toggle out.
    always_ff @(posedge link_clk) begin
        if (!lrst_n) begin
            state <= two_wire_pkg::LS_IDLE;
            op <= two_wire_pkg::OP_START;
            q <= 2'h0;
            nbits <= 4'h0;
            sh <= 9'h1ff;
            held <= 1'b0;
            lk.cap <= 9'h000;
            lk.done_tgl <= 1'b0;
        end else begin
            case (state)
                two_wire_pkg::LS_IDLE: begin
                    if (req_s2 != req_s3) begin
                        op <= lk.op;
                        q <= 2'h0;
                        lk.cap <= 9'h000;
                        state <= two_wire_pkg::LS_BITS;
                        case (lk.op)
                            two_wire_pkg::OP_TX: begin
                                sh <= {lk.tx_byte, 1'b1};
                                nbits <= 4'h9;
                            end
                            two_wire_pkg::OP_RX: begin
                                sh <= 9'h1ff;
                                nbits <= 4'h8;
                            end
                            two_wire_pkg::OP_ACK: begin
                                sh <= {lk.ack_value, 8'hff};
                                nbits <= 4'h1;
                            end
                            default: begin
                                sh <= 9'h1ff;
                                nbits <= 4'h0;
                                state <= two_wire_pkg::LS_COND;
                            end
                        endcase
                    end
                end
                two_wire_pkg::LS_COND: begin
                    if (advance) begin
                        q <= q + 2'h1;
                        if (q == 2'h3) begin
                            state <= two_wire_pkg::LS_IDLE;
                            held <= (op != two_wire_pkg::OP_STOP);
                            lk.done_tgl <= !lk.done_tgl;
                        end
                    end
                end
                two_wire_pkg::LS_BITS: begin
                    if (advance) begin
                        q <= q + 2'h1;
                        if (q == 2'h1) begin
                            lk.cap <= {lk.cap[7:0], sda_s2};
                        end
                        if (q == 2'h3) begin
                            sh <= {sh[7:0], 1'b1};
                            nbits <= nbits - 4'h1;
                            if (nbits == 4'h1) begin
                                state <= two_wire_pkg::LS_IDLE;
                                lk.done_tgl <= !lk.done_tgl;
                            end
                        end
                    end
                end
                default: state <= two_wire_pkg::LS_IDLE;
            endcase
        end
    end

    // Pin levels per quarter; a held bus keeps the clock low between steps.
    always_comb begin
        next_sda_hi = 1'b1;
        next_scl_hi = !held;
        case (state)
            two_wire_pkg::LS_COND: begin
                case (op)
                    two_wire_pkg::OP_START: begin
                        next_sda_hi = (q == 2'h0);
                        next_scl_hi = !q[1];
                    end
                    two_wire_pkg::OP_RESTART: begin
                        next_sda_hi = !q[1];
                        next_scl_hi = (q == 2'h1) || (q == 2'h2);
                    end
                    default: begin
                        next_sda_hi = q[1];
                        next_scl_hi = (q != 2'h0);
                    end
                endcase
            end
            two_wire_pkg::LS_BITS: begin
                next_sda_hi = sh[8];
                next_scl_hi = (q == 2'h1) || (q == 2'h2);
            end
            default: begin
                next_sda_hi = 1'b1;
            end
        endcase
    end

    // Open-drain drive: the pin is pulled low only while its enable is low.
    always_ff @(posedge link_clk) begin
        if (!lrst_n) begin
            sda_oe_n <= 1'b1;
            scl_oe_n <= 1'b1;
        end else begin
            sda_oe_n <= next_sda_hi;
            scl_oe_n <= next_scl_hi;
        end
        sda_out <= 1'b0;
        scl_out <= 1'b0;
    end
endmodule
`default_nettype wire

// file: bench/two_wire_slave.sv
`timescale 1ns/1ps
`default_nettype none
// Serial memory stand-in: acks each written byte and returns rd_byte.
module two_wire_slave (
    input wire logic scl,
    input wire logic sda,
    input wire logic stretch,
    input wire logic [7:0] rd_byte,
    output logic sda_oe_n,
    output logic scl_oe_n,
    output logic [7:0] last,
    output logic ack_seen,
    output logic active
);
    logic [7:0] sh = 0;
    logic [3:0] cnt = 0;
    logic first = 0;
    logic rd = 0;
    initial {sda_oe_n, scl_oe_n, active, last, ack_seen} = 12'hc00;
    // Start, repeated start and stop are SDA moving while SCL is high.
    always @(sda) begin
        if (scl === 1'b1) begin
            active = !sda;
            {cnt, first, rd} = 6'h2;
        end
    end
    // Bits are taken on the rising SCL edge, MSB first.
    always @(posedge scl) begin
        if (active) begin
            if (cnt < 8) sh = {sh[6:0], sda};
            else begin
                // A not-acknowledge from the master ends our sending.
                rd = (rd & !sda) | (first & sh[0]);
                {first, last, ack_seen} = {1'b0, sh, sda};
            end
            cnt = (cnt == 8) ? 4'h0 : cnt + 4'h1;
        end
    end
    // SDA changes only while SCL is low; a stretch holds SCL for 3 us.
    always @(negedge scl) begin
        if (active) begin
            if (cnt == 8 && !rd) sda_oe_n <= 1'b0;
            else if (rd && cnt < 8) sda_oe_n <= rd_byte[3'h7 - cnt[2:0]];
            else sda_oe_n <= 1'b1;
            if (stretch) begin
                scl_oe_n <= 1'b0;
                scl_oe_n <= #3000 1'b1;
            end
        end
    end
endmodule
`default_nettype wire

// file: bench/testbench.sv
`timescale 1ns/1ps
`default_nettype none
`include "two_wire_map.svh"
module testbench;
    logic aclk = 0, link_clk = 0, aresetn = 0, stretch = 0, active, ack_seen;
    logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic awready, wready, bvalid, arready, rvalid, sda_o, scl_o;
    logic sda_oe_n, scl_oe_n, s_sda_oe_n, s_scl_oe_n;
    logic [7:0] awaddr = 0, araddr = 0, last, rd_byte = 0, b, rb;
    logic [31:0] wdata = 0, rdata, d;
    logic [1:0] bresp, rresp, r;
    int bad_count = 0, n_compared = 0, cycles = 0;
    // Open-drain wires with pull-ups: low if any party pulls.
    wire sda = sda_oe_n & s_sda_oe_n;
    wire scl = scl_oe_n & s_scl_oe_n;
    always #2.5 aclk = ~aclk;
    // The link clock starts off phase and never lines up with aclk.
    initial begin
        #3.1;
        forever #7.5 link_clk = ~link_clk;
    end
    two_wire_master_sequencer two_wire_master_sequencer_i (.aclk(aclk),
        .aresetn(aresetn), .link_clk(link_clk), .awaddr(awaddr),
        .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(4'hf),
        .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
        .bready(bready), .araddr(araddr), .arvalid(arvalid),
        .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
        .rready(rready), .data_pin_main_in(sda), .data_pin_main_out(sda_o),
        .data_pin_main_oe_n(sda_oe_n), .clock_pin_main_in(scl),
        .clock_pin_main_out(scl_o), .clock_pin_main_oe_n(scl_oe_n));
    two_wire_slave two_wire_slave_i (.scl(scl), .sda(sda), .stretch(stretch),
        .rd_byte(rd_byte), .sda_oe_n(s_sda_oe_n), .scl_oe_n(s_scl_oe_n),
        .last(last), .ack_seen(ack_seen), .active(active));
    task automatic final_report();
        if (bad_count == 0 && n_compared > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            bad_count++;
            $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask
    // Control word once a request has completed: the request bit, and after a start the
    // clock release bit, are cleared by hardware.
    function automatic logic [31:0] ctl_after(input logic [15:0] v);
        return {16'h0, v & 16'hefe0};
    endfunction
    // Each channel drops valid only at the edge that takes it.
    task automatic axw(input logic [7:0] a, input logic [31:0] v);
        @(posedge aclk);
        {awaddr, wdata, awvalid, wvalid, bready} <= {a, v, 3'b111};
        do begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (awvalid | wvalid);
        while (!bvalid) @(posedge aclk);
        chk(bresp, `RESP_OKAY);
        bready <= 1'b0;
    endtask
    task automatic axr(input logic [7:0] a, output logic [31:0] v,
        output logic [1:0] rs);
        @(posedge aclk);
        {araddr, arvalid, rready} <= {a, 2'b11};
        do @(posedge aclk); while (!arready);
        arvalid <= 1'b0;
        while (!rvalid) @(posedge aclk);
        {v, rs} = {rdata, rresp};
        rready <= 1'b0;
    endtask
    // Polling ends on the bench timeout if a bit never clears.
    task automatic poll(input logic [7:0] a, input logic [31:0] m);
        do axr(a, d, r); while ((d & m) != 0);
    endtask
    task automatic ctl(input logic [15:0] v);
        axw(`OFS_BUS_CONTROL, {16'h0, v});
        poll(`OFS_BUS_CONTROL, 32'h1f);
    endtask
    task automatic send(input logic [7:0] v);
        axw(`OFS_TX_DATA, {24'h0, v});
        poll(`OFS_BUS_STATUS, 32'h6);
        chk(d[`ST_ACK], 1'b0);
        chk(last, v);
    endtask
    always @(posedge aclk) begin
        cycles++;
        if (cycles == 60000) begin
            bad_count++;
            final_report();
        end
    end
    // One full write-then-read transaction with a stretched byte.
    initial begin
        d = $urandom(32'haadfe72a);
        {b, rb} = 16'($urandom);
        rd_byte <= rb;
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        axr(`OFS_BUS_CONTROL, d, r);
        chk(d, `CTL_RESET);
        axr(8'h10, d, r);
        chk({30'h0, r}, {30'h0, `RESP_SLVERR});
        chk(d, 32'h0);
        ctl(16'h8001);
        chk(d, ctl_after(16'h8001));
        chk(active, 1'b1);
        send(8'ha0);
        stretch <= 1'b1;
        send(b);
        stretch <= 1'b0;
        send(~b);
        ctl(16'h8002);
        chk(active, 1'b1);
        send(8'ha1);
        ctl(16'h8008);
        axr(`OFS_RX_DATA, d, r);
        chk(d, {24'h0, rb});
        ctl(16'h8030);
        chk(ack_seen, 1'b1);
        ctl(16'h8004);
        chk(d, ctl_after(16'h8004));
        chk({active, sda, scl}, 3'b011);
        final_report();
    end
endmodule
`default_nettype wire
